// *** bench/lpc_top_props.sv ***
`timescale 1ns/1ps
`default_nettype none

// **********
// Port checks
// **********
module lpc_top_props (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Register bus
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  // Core control
  input wire logic core_sleep,
  input wire logic core_cal_run,
  input wire logic cal_stopped
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);

  bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp)) else $error("write response dropped early");
  rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data dropped early");
  read_latency_a: assert property (s_axi_arvalid && s_axi_arready |=>
    !s_axi_rvalid ##1 s_axi_rvalid) else $error("read answer late");
  write_latency_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid &&
    s_axi_wready |-> ##[1:2] s_axi_bvalid) else $error("write answer late");
  rdata_upper_a: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
    else $error("read data upper bits set");
  error_data_a: assert property (s_axi_rvalid && s_axi_rresp == 2'h2 |->
    s_axi_rdata == 32'h0) else $error("error read returned data");
  sleep_excl_a: assert property (core_sleep |-> !core_cal_run && !cal_stopped)
    else $error("sleep overlaps calibration or stop");
  settle_gap_a: assert property ($fell(core_sleep) |-> !core_cal_run [*2])
    else $error("calibration started without settling");
  sleep_entry_a: assert property ($rose(core_sleep) |-> $past(core_cal_run))
    else $error("sleep entered without calibration");
  stop_idle_a: assert property (cal_stopped |-> !core_cal_run)
    else $error("calibration runs while stopped");
endmodule : lpc_top_props

bind lpc_top lpc_top_props lpc_top_props_i (.sys_clk, .rst, .s_axi_awvalid, .s_axi_awready,
  .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .s_axi_rresp, .core_sleep,
  .core_cal_run, .cal_stopped);

`default_nettype wire

// *** bench/test_lowpower_cal_scheduler.sv ***
`timescale 1ns/1ps
`default_nettype none

module test_lowpower_cal_scheduler;
  logic sys_clk = 1'h0;
  logic rst = 1'h1;
  logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
  logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0, ext_cal_trigger = 1'h1;
  logic [11:0] s_axi_awaddr = 12'h0, s_axi_araddr = 12'h0;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic clk_en = 1'h1;
  logic [7:0] factory_trim_a = 8'h3c, factory_trim_b = 8'hc3;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic core_sleep, core_cal_run, cal_stopped;
  logic [1:0] s_axi_bresp, s_axi_rresp, resp;
  logic [31:0] s_axi_rdata, rdat;
  logic [7:0] gain_trim_a, gain_trim_b;
  int error_cnt = 0;
  int tests_run = 0;

  // Short delays: code 4 sleeps 513 cycles, wake code 1 settles 9
  lpc_top #(.CAL_RUN_CYCLES(8), .DLY_UNIT_CYCLES(43'h1), .DLY_EXP_REDUCE(6'h0f)) lpc_top_i (
    .sys_clk, .rst, .clk_en, .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr,
    .s_axi_awprot(3'h0), .s_axi_wvalid, .s_axi_wready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_arvalid, .s_axi_arready,
    .s_axi_araddr, .s_axi_arprot(3'h0), .s_axi_rvalid, .s_axi_rready, .s_axi_rdata,
    .s_axi_rresp, .ext_cal_trigger, .factory_trim_a, .factory_trim_b, .core_sleep,
    .core_cal_run, .cal_stopped, .gain_trim_a, .gain_trim_b);

  always #5 sys_clk = ~sys_clk;

  // **********
  // Bus and compare helpers
  // **********
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      error_cnt++;
      $display("unexpected %s: expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    logic ad;
    logic wd;
    ad = 1'h0;
    wd = 1'h0;
    @(posedge sys_clk);
    s_axi_awvalid <= 1'h1;
    s_axi_awaddr <= {2'h0, idx, 2'h0};
    s_axi_wvalid <= 1'h1;
    s_axi_wdata <= {24'h0, d};
    s_axi_bready <= 1'h1;
    while (!(ad && wd)) begin
      @(posedge sys_clk);
      if (!ad && s_axi_awready === 1'h1) begin
        ad = 1'h1;
        s_axi_awvalid <= 1'h0;
      end
      if (!wd && s_axi_wready === 1'h1) begin
        wd = 1'h1;
        s_axi_wvalid <= 1'h0;
      end
    end
    do @(posedge sys_clk); while (s_axi_bvalid !== 1'h1);
    resp = s_axi_bresp;
    s_axi_bready <= 1'h0;
  endtask : wr

  task automatic rd(input logic [7:0] idx);
    @(posedge sys_clk);
    s_axi_arvalid <= 1'h1;
    s_axi_araddr <= {2'h0, idx, 2'h0};
    s_axi_rready <= 1'h1;
    do @(posedge sys_clk); while (s_axi_arready !== 1'h1);
    s_axi_arvalid <= 1'h0;
    do @(posedge sys_clk); while (s_axi_rvalid !== 1'h1);
    rdat = s_axi_rdata;
    resp = s_axi_rresp;
    s_axi_rready <= 1'h0;
  endtask : rd

  task automatic rdc(input string nm, input logic [7:0] idx, input logic [7:0] exp);
    rd(idx);
    chk(nm, rdat, {24'h0, exp});
  endtask : rdc

  function automatic logic [7:0] pat(input int i);
    return 8'(i * 7 + 3);
  endfunction : pat

  // **********
  // Scenarios
  // **********
  task automatic t_reset;
    rdc("lp ctrl", lpc_pkg::IDX_LP_CTRL, 8'h88);
    rdc("window enable", lpc_pkg::IDX_DATA_EN, 8'h00);
    rdc("trim a", lpc_pkg::IDX_TRIM_A, 8'h3c);
    rdc("trim b", lpc_pkg::IDX_TRIM_B, 8'hc3);
    chk("trim a pins", {24'h0, gain_trim_a}, 32'h3c);
    chk("stopped", {31'h0, cal_stopped}, 32'h1);
    $display("test reset done");
  endtask : t_reset

  task automatic t_trim;
    wr(lpc_pkg::IDX_TRIM_A, 8'h81);
    wr(lpc_pkg::IDX_TRIM_B, 8'h18);
    rdc("trim a", lpc_pkg::IDX_TRIM_A, 8'h81);
    rdc("trim b", lpc_pkg::IDX_TRIM_B, 8'h18);
    chk("trim b pins", {24'h0, gain_trim_b}, 32'h18);
    // Lane 0 masked: accepted but must not change the trim
    s_axi_wstrb <= 4'he;
    wr(lpc_pkg::IDX_TRIM_A, 8'h55);
    chk("masked write resp", {30'h0, resp}, 32'h0);
    s_axi_wstrb <= 4'hf;
    rdc("trim a masked", lpc_pkg::IDX_TRIM_A, 8'h81);
    rd(8'h75);
    chk("unmapped read", rdat, 32'h0);
    chk("unmapped read resp", {30'h0, resp}, 32'h2);
    wr(8'h75, 8'h11);
    chk("unmapped write", {30'h0, resp}, 32'h2);
    $display("test trim done");
  endtask : t_trim

  task automatic t_timed;
    int n;
    wr(lpc_pkg::IDX_LP_CTRL, 8'h89);
    repeat (40) @(posedge sys_clk);
    chk("sleep with cal off", {31'h0, core_sleep}, 32'h0);
    wr(lpc_pkg::IDX_LP_CTRL, 8'h88);
    wr(lpc_pkg::IDX_CTRL, 8'h05);
    repeat (40) @(posedge sys_clk);
    chk("sleep with lp off", {31'h0, core_sleep}, 32'h0);
    wr(lpc_pkg::IDX_LP_CTRL, 8'h89);
    do @(posedge sys_clk); while (core_sleep !== 1'h1);
    n = 0;
    while (core_sleep === 1'h1) begin
      n++;
      @(posedge sys_clk);
    end
    chk("sleep length", n, 513);
    n = 0;
    while (core_cal_run !== 1'h1) begin
      n++;
      @(posedge sys_clk);
    end
    chk("settle length", n, 9);
    // Freeze longer than a calibration run; the run must not end meanwhile
    clk_en <= 1'h0;
    repeat (20) @(posedge sys_clk);
    chk("frozen run", {30'h0, core_sleep, core_cal_run}, 32'h1);
    clk_en <= 1'h1;
    n = 0;
    while (core_sleep !== 1'h1) begin
      n++;
      @(posedge sys_clk);
    end
    // One run cycle passed before the freeze, seven after it, seen one edge late
    chk("run after freeze", n, 8);
    $display("test timed done");
  endtask : t_timed

  task automatic t_trig;
    wr(lpc_pkg::IDX_CTRL, 8'h03);
    wr(lpc_pkg::IDX_LP_CTRL, 8'h8b);
    do @(posedge sys_clk); while (core_sleep !== 1'h1);
    repeat (600) @(posedge sys_clk);
    chk("held asleep", {31'h0, core_sleep}, 32'h1);
    ext_cal_trigger <= 1'h0;
    repeat (8) @(posedge sys_clk);
    chk("woken by trigger", {31'h0, core_sleep}, 32'h0);
    ext_cal_trigger <= 1'h1;
    do @(posedge sys_clk); while (core_sleep !== 1'h1);
    wr(lpc_pkg::IDX_CTRL, 8'h01);
    repeat (3) @(posedge sys_clk);
    chk("woken by soft trigger", {31'h0, core_sleep}, 32'h0);
    $display("test trigger done");
  endtask : t_trig

  task automatic t_window;
    wr(lpc_pkg::IDX_CTRL, 8'h0d);
    repeat (3) @(posedge sys_clk);
    chk("stopped pins", {cal_stopped, core_cal_run}, 32'h2);
    rdc("status stopped", lpc_pkg::IDX_STATUS, 8'h11);
    wr(lpc_pkg::IDX_DATA, 8'h5a);
    rdc("closed window", lpc_pkg::IDX_DATA, 8'h00);
    wr(lpc_pkg::IDX_DATA_EN, 8'h01);
    for (int i = 0; i < 673; i++) wr(lpc_pkg::IDX_DATA, pat(i));
    rdc("status valid", lpc_pkg::IDX_STATUS, 8'h13);
    wr(lpc_pkg::IDX_DATA_EN, 8'h00);
    wr(lpc_pkg::IDX_DATA_EN, 8'h01);
    for (int i = 0; i < 675; i++) rdc("window", lpc_pkg::IDX_DATA, pat(i % 673));
    wr(lpc_pkg::IDX_DATA_EN, 8'h00);
    wr(lpc_pkg::IDX_DATA_EN, 8'h01);
    rdc("window restart", lpc_pkg::IDX_DATA, pat(0));
    rdc("status invalid", lpc_pkg::IDX_STATUS, 8'h11);
    wr(lpc_pkg::IDX_CTRL, 8'h05);
    repeat (2) @(posedge sys_clk);
    chk("resumed pins", {cal_stopped, core_cal_run}, 32'h1);
    $display("test window done");
  endtask : t_window

  task automatic end_sim;
    $display("checks %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : end_sim

  initial begin
    repeat (3) @(posedge sys_clk);
    rst <= 1'h0;
    t_reset;
    t_trim;
    t_timed;
    t_trig;
    t_window;
    end_sim;
  end

  initial begin
    #400000;
    error_cnt++;
    $display("watchdog expired");
    end_sim;
  end
endmodule : test_lowpower_cal_scheduler

`default_nettype wire

// *** inc/lpc_pkg.sv ***
package lpc_pkg;

  // ****************************************
  // Register indices (byte address = 4 x index)
  // ****************************************
  localparam logic [7:0] IDX_STATUS = 8'h6a;
  localparam logic [7:0] IDX_CTRL = 8'h6c;
  localparam logic [7:0] IDX_LP_CTRL = 8'h6e;
  localparam logic [7:0] IDX_DATA_EN = 8'h70;
  localparam logic [7:0] IDX_DATA = 8'h71;
  localparam logic [7:0] IDX_TRIM_A = 8'h7a;
  localparam logic [7:0] IDX_TRIM_B = 8'h7b;

  // ****************************************
  // Field layouts and reset values
  // ****************************************
  localparam logic [7:0] LP_CTRL_RST = 8'h88;
  localparam int unsigned LP_SLEEP_LSB = 5;
  localparam int unsigned LP_SLEEP_MSB = 7;
  localparam int unsigned LP_WAKE_LSB = 3;
  localparam int unsigned LP_WAKE_MSB = 4;
  localparam int unsigned TRIGGER_WAIT_MODE_BIT = 1;
  localparam int unsigned LOWPOWER_ENABLE_BIT = 0;

  localparam logic [7:0] CTRL_RST = 8'h04;
  localparam int unsigned CTRL_BG_BIT = 0;
  localparam int unsigned CTRL_TSRC_BIT = 1;
  localparam int unsigned CTRL_SOFT_BIT = 2;
  localparam int unsigned CTRL_STOP_BIT = 3;

  localparam logic [7:0] DATA_EN_RST = 8'h00;
  localparam int unsigned DATA_EN_BIT = 0;

  localparam int unsigned STAT_STOP_BIT = 0;
  localparam int unsigned STAT_VALID_BIT = 1;
  localparam int unsigned STAT_STATE_LSB = 2;

  // ****************************************
  // Calibration vector and delays
  // ****************************************
  localparam int unsigned CAL_WORDS = 673;
  localparam int unsigned DLY_UNIT = 256;
  localparam logic [7:0][5:0] SLEEP_EXP = {6'h21, 6'h1e, 6'h1b, 6'h18,
                                           6'h15, 6'h12, 6'h0f, 6'h03};
  localparam logic [3:0][5:0] WAKE_EXP = {6'h18, 6'h15, 6'h12, 6'h03};

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [2:0] {
    REG_NONE = 3'h0,
    REG_STATUS = 3'h1,
    REG_CTRL = 3'h2,
    REG_LP_CTRL = 3'h3,
    REG_DATA_EN = 3'h4,
    REG_DATA = 3'h5,
    REG_TRIM_A = 3'h6,
    REG_TRIM_B = 3'h7
  } lpc_reg_type;

  typedef enum logic [2:0] {
    SCH_OFF = 3'h0,
    SCH_CAL = 3'h1,
    SCH_SLEEP = 3'h2,
    SCH_SETTLE = 3'h3,
    SCH_STOP = 3'h4
  } lpc_sched_type;

endpackage : lpc_pkg

// *** verilog/lpc_cal_mem.sv ***
`timescale 1ns/1ps
`default_nettype none

module lpc_cal_mem #(
  parameter int unsigned DEPTH = 673,
  parameter int unsigned AW = 10,
  parameter int unsigned DW = 8
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic clk_en,
  // Access
  input wire logic wr_en,
  input wire logic rd_en,
  input wire logic [AW-1:0] addr,
  input wire logic [DW-1:0] wdata,
  output logic [DW-1:0] rdata
);

  typedef struct packed {
    logic [DEPTH-1:0][DW-1:0] mem;
    logic [DW-1:0] q;
  } lpc_mem_st_type;

  lpc_mem_st_type st_ff;
  lpc_mem_st_type nxt_st;

  always_comb begin
    nxt_st = st_ff;
    if (wr_en) begin
      nxt_st.mem[addr] = wdata;
    end
    if (rd_en) begin
      nxt_st.q = st_ff.mem[addr];
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      st_ff <= '0;
    end else if (clk_en) begin
      st_ff <= nxt_st;
    end
  end

  assign rdata = st_ff.q;

endmodule : lpc_cal_mem

`default_nettype wire

// *** verilog/lpc_sync.sv ***
`timescale 1ns/1ps
`default_nettype none

module lpc_sync #(
  parameter logic RST_VAL = 1'b1
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic clk_en,
  // Level
  input wire logic din,
  output logic dout
);

  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic q;
  } lpc_sync_st_type;

  lpc_sync_st_type st_ff;
  lpc_sync_st_type nxt_st;

  always_comb begin
    nxt_st = st_ff;
    nxt_st.s1 = din;
    nxt_st.s2 = st_ff.s1;
    nxt_st.s3 = st_ff.s2;
    // Accept a change only once two later stages agree
    if (st_ff.s2 == st_ff.s3) begin
      nxt_st.q = st_ff.s3;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      st_ff <= {4{RST_VAL}};
    end else if (clk_en) begin
      st_ff <= nxt_st;
    end
  end

  assign dout = st_ff.q;

endmodule : lpc_sync

`default_nettype wire

// *** verilog/lpc_top.sv ***
// Design decision made here: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none

module lpc_top #(
  parameter int unsigned ADDR_W = 12,
  parameter int unsigned CAL_RUN_CYCLES = 64,
  parameter logic [42:0] DLY_UNIT_CYCLES = 43'(lpc_pkg::DLY_UNIT),
  parameter logic [5:0] DLY_EXP_REDUCE = 6'h00
) (
  // Clock, reset, enable
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic clk_en,
  // AXI4-Lite write address
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  // AXI4-Lite write data and response
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  output logic [1:0] s_axi_bresp,
  // AXI4-Lite read
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  // Calibration trigger pin and factory trims
  input wire logic ext_cal_trigger,
  input wire logic [7:0] factory_trim_a,
  input wire logic [7:0] factory_trim_b,
  // Core control
  output logic core_sleep,
  output logic core_cal_run,
  output logic cal_stopped,
  output logic [7:0] gain_trim_a,
  output logic [7:0] gain_trim_b
);

  localparam int unsigned IDX_W = $clog2(lpc_pkg::CAL_WORDS);
  localparam int unsigned CNT_W = 43;
  localparam logic [IDX_W-1:0] IDX_LAST = IDX_W'(lpc_pkg::CAL_WORDS - 1);
  localparam logic [CNT_W-1:0] CAL_LOAD = CNT_W'(CAL_RUN_CYCLES - 1);

  typedef struct packed {
    logic awready;
    logic wready;
    logic arready;
    logic aw_have;
    logic [ADDR_W-1:0] awaddr;
    logic w_have;
    logic [7:0] wdata;
    logic wlane0;
    logic bvalid;
    logic [1:0] bresp;
    logic rd_pend;
    lpc_pkg::lpc_reg_type rsel;
    logic rwin;
    logic rvalid;
    logic [7:0] rdata;
    logic [1:0] rresp;
    logic [7:0] lp_ctrl;
    logic [7:0] ctrl;
    logic [7:0] data_en;
    logic [7:0] trim_a;
    logic [7:0] trim_b;
    logic trim_loaded;
    logic [IDX_W-1:0] cal_idx;
    logic cal_valid;
    lpc_pkg::lpc_sched_type sched;
    logic [CNT_W-1:0] cnt;
    logic core_sleep;
    logic cal_run;
    logic stopped;
  } lpc_top_st_type;

  lpc_top_st_type st_ff;
  lpc_top_st_type nxt_st;
  logic trig_pin;
  logic [7:0] mem_q;
  logic mem_rd;
  logic mem_wr;

  // ****************************************
  // Helpers
  // ****************************************
  function automatic lpc_pkg::lpc_reg_type reg_decode(input logic [ADDR_W-1:0] a);
    logic [ADDR_W-3:0] idx;
    idx = a[ADDR_W-1:2];
    reg_decode = lpc_pkg::REG_NONE;
    if (a[1:0] == 2'h0) begin
      if (idx == (ADDR_W-2)'(lpc_pkg::IDX_STATUS)) reg_decode = lpc_pkg::REG_STATUS;
      if (idx == (ADDR_W-2)'(lpc_pkg::IDX_CTRL)) reg_decode = lpc_pkg::REG_CTRL;
      if (idx == (ADDR_W-2)'(lpc_pkg::IDX_LP_CTRL)) reg_decode = lpc_pkg::REG_LP_CTRL;
      if (idx == (ADDR_W-2)'(lpc_pkg::IDX_DATA_EN)) reg_decode = lpc_pkg::REG_DATA_EN;
      if (idx == (ADDR_W-2)'(lpc_pkg::IDX_DATA)) reg_decode = lpc_pkg::REG_DATA;
      if (idx == (ADDR_W-2)'(lpc_pkg::IDX_TRIM_A)) reg_decode = lpc_pkg::REG_TRIM_A;
      if (idx == (ADDR_W-2)'(lpc_pkg::IDX_TRIM_B)) reg_decode = lpc_pkg::REG_TRIM_B;
    end
  endfunction : reg_decode

  // Delay of (2^(k - DLY_EXP_REDUCE) + 1) units, exponent floored at 0, minus one for a count-to-zero timer
  function automatic logic [CNT_W-1:0] dly_cnt(input logic [5:0] k);
    logic [5:0] ke;
    logic [CNT_W-1:0] base;
    ke = (k > DLY_EXP_REDUCE) ? 6'(k - DLY_EXP_REDUCE) : 6'h00;
    base = (CNT_W'(1) << ke) + CNT_W'(1);
    dly_cnt = CNT_W'(base * DLY_UNIT_CYCLES) - CNT_W'(1);
  endfunction : dly_cnt

  // ****************************************
  // Submodules
  // ****************************************
  lpc_sync #(
    .RST_VAL(1'b1)
  ) lpc_sync_i (
    .sys_clk(sys_clk),
    .rst(rst),
    .clk_en(clk_en),
    .din(ext_cal_trigger),
    .dout(trig_pin)
  );

  lpc_cal_mem #(
    .DEPTH(lpc_pkg::CAL_WORDS),
    .AW(IDX_W),
    .DW(8)
  ) lpc_cal_mem_i (
    .sys_clk(sys_clk),
    .rst(rst),
    .clk_en(clk_en),
    .wr_en(mem_wr),
    .rd_en(mem_rd),
    .addr(st_ff.cal_idx),
    .wdata(st_ff.wdata),
    .rdata(mem_q)
  );

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    logic ar_take;
    logic wr_go;
    logic wr_hit;
    logic win_on;
    lpc_pkg::lpc_reg_type wsel;
    lpc_pkg::lpc_reg_type asel;
    logic bg;
    logic lp;
    logic trig;
    logic cnt_done;
    nxt_st = st_ff;
    ar_take = s_axi_arvalid && st_ff.arready;
    wr_go = st_ff.aw_have && st_ff.w_have && !st_ff.bvalid && !ar_take;
    wsel = reg_decode(st_ff.awaddr);
    asel = reg_decode(s_axi_araddr);
    wr_hit = wr_go && st_ff.wlane0;
    win_on = st_ff.data_en[lpc_pkg::DATA_EN_BIT];
    bg = st_ff.ctrl[lpc_pkg::CTRL_BG_BIT];
    lp = st_ff.lp_ctrl[lpc_pkg::LOWPOWER_ENABLE_BIT] && bg;
    trig = st_ff.ctrl[lpc_pkg::CTRL_TSRC_BIT] ? trig_pin
         : st_ff.ctrl[lpc_pkg::CTRL_SOFT_BIT];
    cnt_done = (st_ff.cnt == '0);
    mem_rd = ar_take && (asel == lpc_pkg::REG_DATA) && win_on;
    mem_wr = wr_hit && (wsel == lpc_pkg::REG_DATA) && win_on;

    // Factory trims taken once, first enabled cycle after reset
    if (!st_ff.trim_loaded) begin
      nxt_st.trim_a = factory_trim_a;
      nxt_st.trim_b = factory_trim_b;
      nxt_st.trim_loaded = 1'b1;
    end

    // Write address and data, taken in either order
    if (s_axi_awvalid && st_ff.awready) begin
      nxt_st.aw_have = 1'b1;
      nxt_st.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && st_ff.wready) begin
      nxt_st.w_have = 1'b1;
      nxt_st.wdata = s_axi_wdata[7:0];
      nxt_st.wlane0 = s_axi_wstrb[0];
    end
    if (st_ff.bvalid && s_axi_bready) begin
      nxt_st.bvalid = 1'b0;
    end
    if (wr_go) begin
      nxt_st.aw_have = 1'b0;
      nxt_st.w_have = 1'b0;
      nxt_st.bvalid = 1'b1;
      nxt_st.bresp = (wsel == lpc_pkg::REG_NONE) ? lpc_pkg::RESP_SLVERR : lpc_pkg::RESP_OKAY;
    end
    if (wr_hit) begin
      unique case (wsel)
        lpc_pkg::REG_CTRL: nxt_st.ctrl = st_ff.wdata;
        lpc_pkg::REG_LP_CTRL: nxt_st.lp_ctrl = st_ff.wdata;
        lpc_pkg::REG_DATA_EN: nxt_st.data_en = st_ff.wdata;
        lpc_pkg::REG_TRIM_A: nxt_st.trim_a = st_ff.wdata;
        lpc_pkg::REG_TRIM_B: nxt_st.trim_b = st_ff.wdata;
        default: ;
      endcase
    end

    // Read path: decode at take, data one cycle later
    if (st_ff.rvalid && s_axi_rready) begin
      nxt_st.rvalid = 1'b0;
    end
    if (ar_take) begin
      nxt_st.rd_pend = 1'b1;
      nxt_st.rsel = asel;
      nxt_st.rwin = win_on;
    end
    if (st_ff.rd_pend) begin
      nxt_st.rd_pend = 1'b0;
      nxt_st.rvalid = 1'b1;
      nxt_st.rresp = lpc_pkg::RESP_OKAY;
      unique case (st_ff.rsel)
        lpc_pkg::REG_NONE: begin
          nxt_st.rdata = 8'h00;
          nxt_st.rresp = lpc_pkg::RESP_SLVERR;
        end
        lpc_pkg::REG_STATUS: begin
          nxt_st.rdata = 8'h00;
          nxt_st.rdata[lpc_pkg::STAT_STOP_BIT] = st_ff.stopped;
          nxt_st.rdata[lpc_pkg::STAT_VALID_BIT] = st_ff.cal_valid;
          nxt_st.rdata[lpc_pkg::STAT_STATE_LSB +: 3] = st_ff.sched;
        end
        lpc_pkg::REG_CTRL: nxt_st.rdata = st_ff.ctrl;
        lpc_pkg::REG_LP_CTRL: nxt_st.rdata = st_ff.lp_ctrl;
        lpc_pkg::REG_DATA_EN: nxt_st.rdata = st_ff.data_en;
        lpc_pkg::REG_DATA: nxt_st.rdata = st_ff.rwin ? mem_q : 8'h00;
        lpc_pkg::REG_TRIM_A: nxt_st.rdata = st_ff.trim_a;
        lpc_pkg::REG_TRIM_B: nxt_st.rdata = st_ff.trim_b;
      endcase
    end

    // Window index and vector validity
    if (mem_rd || mem_wr) begin
      if (st_ff.cal_idx == '0) begin
        nxt_st.cal_valid = 1'b0;
      end
      if (st_ff.cal_idx == IDX_LAST) begin
        nxt_st.cal_idx = '0;
        nxt_st.cal_valid = 1'b1;
      end else begin
        nxt_st.cal_idx = st_ff.cal_idx + IDX_W'(1);
      end
    end
    if (!nxt_st.data_en[lpc_pkg::DATA_EN_BIT]) begin
      nxt_st.cal_idx = '0;
      if (st_ff.cal_idx != '0) begin
        nxt_st.cal_valid = 1'b0;
      end
    end

    // Scheduler
    if (!cnt_done) begin
      nxt_st.cnt = st_ff.cnt - CNT_W'(1);
    end
    unique case (st_ff.sched)
      lpc_pkg::SCH_OFF: begin
        if (bg) begin
          nxt_st.sched = lpc_pkg::SCH_CAL;
          nxt_st.cnt = CAL_LOAD;
        end
      end
      lpc_pkg::SCH_CAL: begin
        if (cnt_done) begin
          if (lp) begin
            nxt_st.sched = lpc_pkg::SCH_SLEEP;
            nxt_st.cnt = dly_cnt(lpc_pkg::SLEEP_EXP[
              st_ff.lp_ctrl[lpc_pkg::LP_SLEEP_MSB:lpc_pkg::LP_SLEEP_LSB]]);
          end else begin
            nxt_st.cnt = CAL_LOAD;
          end
        end
      end
      lpc_pkg::SCH_SLEEP: begin
        if (!lp || (st_ff.lp_ctrl[lpc_pkg::TRIGGER_WAIT_MODE_BIT] ? !trig : cnt_done)) begin
          nxt_st.sched = lpc_pkg::SCH_SETTLE;
          nxt_st.cnt = dly_cnt(lpc_pkg::WAKE_EXP[
            st_ff.lp_ctrl[lpc_pkg::LP_WAKE_MSB:lpc_pkg::LP_WAKE_LSB]]);
        end
      end
      lpc_pkg::SCH_SETTLE: begin
        if (cnt_done) begin
          nxt_st.sched = lpc_pkg::SCH_CAL;
          nxt_st.cnt = CAL_LOAD;
        end
      end
      lpc_pkg::SCH_STOP: begin
        if (!st_ff.ctrl[lpc_pkg::CTRL_STOP_BIT]) begin
          nxt_st.sched = lpc_pkg::SCH_CAL;
          nxt_st.cnt = CAL_LOAD;
        end
      end
      default: nxt_st.sched = lpc_pkg::SCH_OFF;
    endcase
    if (!bg) begin
      nxt_st.sched = lpc_pkg::SCH_OFF;
    end else if (st_ff.ctrl[lpc_pkg::CTRL_STOP_BIT]) begin
      nxt_st.sched = lpc_pkg::SCH_STOP;
    end

    // Registered outputs
    nxt_st.core_sleep = (nxt_st.sched == lpc_pkg::SCH_SLEEP);
    nxt_st.cal_run = (nxt_st.sched == lpc_pkg::SCH_CAL);
    nxt_st.stopped = (nxt_st.sched == lpc_pkg::SCH_STOP)
                  || (nxt_st.sched == lpc_pkg::SCH_OFF);
    nxt_st.awready = !nxt_st.aw_have;
    nxt_st.wready = !nxt_st.w_have;
    nxt_st.arready = !nxt_st.rd_pend && !nxt_st.rvalid;
  end

  // ****************************************
  // State register
  // ****************************************
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      st_ff <= '0;
      st_ff.awready <= 1'b1;
      st_ff.wready <= 1'b1;
      st_ff.arready <= 1'b1;
      st_ff.lp_ctrl <= lpc_pkg::LP_CTRL_RST;
      st_ff.ctrl <= lpc_pkg::CTRL_RST;
      st_ff.data_en <= lpc_pkg::DATA_EN_RST;
      st_ff.sched <= lpc_pkg::SCH_OFF;
      st_ff.stopped <= 1'b1;
    end else if (clk_en) begin
      st_ff <= nxt_st;
    end
  end

  assign s_axi_awready = st_ff.awready;
  assign s_axi_wready = st_ff.wready;
  assign s_axi_arready = st_ff.arready;
  assign s_axi_bvalid = st_ff.bvalid;
  assign s_axi_bresp = st_ff.bresp;
  assign s_axi_rvalid = st_ff.rvalid;
  assign s_axi_rdata = {24'h000000, st_ff.rdata};
  assign s_axi_rresp = st_ff.rresp;
  assign core_sleep = st_ff.core_sleep;
  assign core_cal_run = st_ff.cal_run;
  assign cal_stopped = st_ff.stopped;
  assign gain_trim_a = st_ff.trim_a;
  assign gain_trim_b = st_ff.trim_b;

endmodule : lpc_top

`default_nettype wire
